// [rtl/alert_status_mask_logic.sv]
// Alert status flags, mask registers and alert output of the monitor.
//
// Operation
// R1 - Pushed status bits 0-3 report alert caused by pushed temperature 0-3.
// R2 - Pushed status bits 4-7 report overtemp output caused by pushes 0-3.
// R3 - Pushed mask bits 0-3 block pushed alerts; bits 4-7 read-only.
// R4 - CPU status bit 0 sets when a transaction returns a completion code.
// R5 - CPU status bit 1 reads 1 once overtemp timer exceeds its limit.
// R6 - CPU status bit 2 reads 1 on generic instruction cpu_error_mask_a error.
// R7 - CPU status bits 3-5 flag channels 1-3 outside high or low limit.
// R8 - CPU status bit 6 flags short block read count: 2 hub, 9 modules.
// R9 - CPU status bit 7 flags rail voltage; read clears only if gone.
// R10 - Error mask bit 0 blocks channel 0 out-of-limit alerts.
// R11 - Error mask bits 1-2 block data/cpu_error_mask_a alerts and fan override.
// R12 - Error mask bit 3 blocks overtemperature alerts.
// R13 - Software also sets the summary mask elsewhere when masking here.
// R14 - CPU mask bits 0-2 block completion, timer and cpu_error_mask_a alerts.
// R15 - CPU mask bits 3-5 block channel 1-3 out-of-limit alerts.
// R16 - CPU mask bit 6 blocks byte count, bit 7 rail voltage alerts.
// R17 - Software also sets the summary mask when masking CPU events.
// R18 - Alert active when any unmasked flag is set; all zero at reset.
// R19 - Flags set by hardware only; status writes have no effect.
`include "alert_params.svh"

module alert_status_mask_logic (
  input wire logic sys_clk_i, // 20 MHz system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [7:0] reg_addr_i, // register address
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [7:0] reg_wdata_i, // register write data
  output logic [7:0] reg_rdata_o, // register read data
  input wire logic [3:0] push_alert_evt_i, // pushed temp alert events
  input wire logic [3:0] push_overtemp_evt_i, // pushed temp overtemp events
  input wire logic completion_code_evt_i, // completion code returned
  input wire logic overtemp_timer_exceeded_i, // timer above its limit
  input wire logic generic_cpu_error_mask_a_err_evt_i, // generic instr cpu_error_mask_a error
  input wire logic [3:0] cpu_limit_evt_i, // channel 0-3 out of limit
  input wire logic cpu_data_err_i, // channel data error present
  input wire logic cpu_cpu_error_mask_a_err_i, // channel cpu_error_mask_a error present
  input wire logic overtemp_cond_i, // overtemperature condition
  input wire logic block_read_done_i, // block read finished pulse
  input wire logic [7:0] block_read_count_i, // returned byte count
  input wire logic dimm_read_mode_i, // module temps also read
  input wire logic vtt_sample_valid_i, // new rail voltage sample
  input wire logic [7:0] vtt_value_i, // rail voltage reading
  input wire logic [7:0] vtt_high_limit_i, // rail voltage high limit
  output logic alert_o, // alert output, active high
  output logic fan_override_o // fan override request
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // A source reaches the alert only while its mask bit is clear.
  function automatic logic unmasked(input logic cause,
                                    input logic mask_bit);
    unmasked = cause && !mask_bit;
  endfunction

  alert_pkg::reg_req_t req;
  assign req = '{addr: reg_addr_i, wr: reg_wr_i, rd: reg_rd_i,
                 wdata: reg_wdata_i};

  logic rd_push_status;
  logic rd_cpu_status;
  assign rd_push_status = req.rd && hit(req.addr, `ADDR_PUSH_STATUS);
  assign rd_cpu_status = req.rd && hit(req.addr, `ADDR_CPU_STATUS);

  // ****************************************************************
  // Mask and limit registers
  // ****************************************************************
  logic [7:0] push_mask_reg;
  logic [7:0] push_mask_next;
  logic [7:0] err_mask_reg;
  logic [7:0] err_mask_next;
  logic [7:0] cpu_mask_reg;
  logic [7:0] cpu_mask_next;
  logic [7:0] vtt_low_reg;
  logic [7:0] vtt_low_next;

  // Status offsets are not decoded for writes, so those writes are dropped.
  always_comb begin
    push_mask_next = push_mask_reg;
    err_mask_next = err_mask_reg;
    cpu_mask_next = cpu_mask_reg;
    vtt_low_next = vtt_low_reg;
    if (req.wr) begin // [R19]
      if (hit(req.addr, `ADDR_PUSH_MASK)) begin
        push_mask_next = req.wdata & `PUSH_MASK_WMASK; // [R3]
      end
      if (hit(req.addr, `ADDR_ERR_MASK)) begin
        err_mask_next = req.wdata & `ERR_MASK_WMASK;
      end
      if (hit(req.addr, `ADDR_CPU_MASK)) begin
        cpu_mask_next = req.wdata & `CPU_MASK_WMASK;
      end
      if (hit(req.addr, `ADDR_VTT_LOW)) begin
        vtt_low_next = req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      push_mask_reg <= `RESET_BYTE; // [R18]
      err_mask_reg <= `RESET_BYTE;
      cpu_mask_reg <= `RESET_BYTE;
      vtt_low_reg <= `RESET_BYTE;
    end else begin
      push_mask_reg <= push_mask_next;
      err_mask_reg <= err_mask_next;
      cpu_mask_reg <= cpu_mask_next;
      vtt_low_reg <= vtt_low_next;
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  logic vtt_outside;
  logic vtt_outside_q;
  logic short_count;
  logic [7:0] min_count;

  limit_window_check #(
    .WIDTH(8)
  ) u_vtt_check (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(vtt_sample_valid_i),
    .value_i(vtt_value_i),
    .low_i(vtt_low_reg),
    .high_i(vtt_high_limit_i),
    .outside_o(vtt_outside)
  );

  // The hub alone returns fewer bytes than a read that includes modules.
  assign min_count = dimm_read_mode_i ? `MIN_COUNT_DIMM : `MIN_COUNT_HUB;
  assign short_count = block_read_done_i
                       && (block_read_count_i < min_count); // [R8]

  // The rail flag sets on the step into the fault, so a read that finds the
  // rail back in window clears it until the next excursion.
  logic vtt_outside_prev;
  logic vtt_outside_prev_next;
  always_comb begin
    vtt_outside_prev_next = vtt_outside;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vtt_outside_prev <= 1'b0;
    end else begin
      vtt_outside_prev <= vtt_outside_prev_next;
    end
  end
  assign vtt_outside_q = vtt_outside && !vtt_outside_prev;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  alert_pkg::push_status_t push_set;
  alert_pkg::push_status_t push_status;
  alert_pkg::cpu_status_t cpu_set;
  alert_pkg::cpu_status_t cpu_hold;
  alert_pkg::cpu_status_t cpu_status;

  always_comb begin
    push_set.alert = push_alert_evt_i; // [R1]
    push_set.overtemp = push_overtemp_evt_i; // [R2]
  end

  always_comb begin
    cpu_set.completion_code = completion_code_evt_i; // [R4]
    cpu_set.overtemp_timer = overtemp_timer_exceeded_i; // [R5]
    cpu_set.generic_cpu_error_mask_a = generic_cpu_error_mask_a_err_evt_i; // [R6]
    cpu_set.cpu_ch_limit = cpu_limit_evt_i[3:1]; // [R7]
    cpu_set.short_byte_count = short_count; // [R8]
    cpu_set.io_rail = vtt_outside_q; // [R9]
    cpu_hold = '0;
    cpu_hold.io_rail = vtt_outside; // [R9]
  end

  // Only the rail flag holds through a read; every other flag is a plain
  // clear-on-read latch of its event.
  logic [7:0] push_flags;
  logic [7:0] cpu_flags;

  event_flag_bank #(
    .WIDTH(8)
  ) u_push_flags (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(push_set),
    .hold_i(8'h00),
    .clr_i(rd_push_status),
    .flags_o(push_flags)
  );

  event_flag_bank #(
    .WIDTH(8)
  ) u_cpu_flags (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(cpu_set),
    .hold_i(cpu_hold),
    .clr_i(rd_cpu_status),
    .flags_o(cpu_flags)
  );

  assign push_status = push_flags;
  assign cpu_status = cpu_flags;

  // ****************************************************************
  // Alert and fan override
  // ****************************************************************
  logic alert_reg;
  logic alert_next;
  logic fan_reg;
  logic fan_next;
  logic [3:0] push_alert_src;
  logic data_err_live;
  logic cpu_error_mask_a_err_live;
  logic push_alert_any;
  logic push_ovt_any;
  logic err_alert_any;
  logic cpu_alert_any;

  // Each pushed temperature alert is gated by its own mask bit.
  for (genvar i = 0; i < 4; i++) begin : g_push_src
    assign push_alert_src[i] = unmasked(push_status.alert[i],
                                        push_mask_reg[i]); // [R3]
  end

  // The summary mask lives in another block, so the masks here gate each
  // source directly and software is expected to set both.
  always_comb begin
    data_err_live = unmasked(cpu_data_err_i,
                             err_mask_reg[`ERR_MASK_DATA]); // [R11]
    cpu_error_mask_a_err_live = unmasked(cpu_cpu_error_mask_a_err_i,
                             err_mask_reg[`ERR_MASK_CPU_ERROR_MASK_A]); // [R11]
    push_alert_any = |push_alert_src; // [R3]
    push_ovt_any = unmasked(|push_status.overtemp,
                            err_mask_reg[`ERR_MASK_OVT]); // [R12]
    err_alert_any = unmasked(cpu_limit_evt_i[0],
                             err_mask_reg[`ERR_MASK_CH0]) // [R10]
                    || data_err_live || cpu_error_mask_a_err_live // [R11]
                    || unmasked(overtemp_cond_i,
                                err_mask_reg[`ERR_MASK_OVT]); // [R12]
    cpu_alert_any = |(cpu_status & ~cpu_mask_reg); // [R14] [R15] [R16]
    alert_next = push_alert_any || push_ovt_any
                 || err_alert_any || cpu_alert_any; // [R18]
    fan_next = data_err_live || cpu_error_mask_a_err_live; // [R11]
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alert_reg <= 1'b0;
      fan_reg <= 1'b0;
    end else begin
      alert_reg <= alert_next;
      fan_reg <= fan_next;
    end
  end

  assign alert_o = alert_reg;
  assign fan_override_o = fan_reg;

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Read data is captured with the strobe and holds until the next read.
  always_comb begin
    rdata_next = rdata_reg;
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_PUSH_STATUS: rdata_next = push_status;
        `ADDR_PUSH_MASK: rdata_next = push_mask_reg;
        `ADDR_CPU_STATUS: rdata_next = cpu_status;
        `ADDR_ERR_MASK: rdata_next = err_mask_reg;
        `ADDR_CPU_MASK: rdata_next = cpu_mask_reg;
        `ADDR_VTT_LOW: rdata_next = vtt_low_reg;
        default: rdata_next = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= `RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

// [include/alert_params.svh]
// Register offsets, reset values, field positions and limits of the alert block.
`ifndef ALERT_PARAMS_SVH
`define ALERT_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_PUSH_STATUS 8'h7E
`define ADDR_PUSH_MASK 8'h7F
`define ADDR_CPU_STATUS 8'h81
`define ADDR_ERR_MASK 8'h82
`define ADDR_CPU_MASK 8'h83
`define ADDR_VTT_LOW 8'h84

// ****************************************************************
// Reset values and writable fields
// ****************************************************************
`define RESET_BYTE 8'h00
`define PUSH_MASK_WMASK 8'h0F
`define ERR_MASK_WMASK 8'h7F
`define CPU_MASK_WMASK 8'hFF

// ****************************************************************
// Error mask bit positions
// ****************************************************************
`define ERR_MASK_CH0 0
`define ERR_MASK_DATA 1
`define ERR_MASK_CPU_ERROR_MASK_A 2
`define ERR_MASK_OVT 3

// ****************************************************************
// Block read byte count minimums
// ****************************************************************
`define MIN_COUNT_HUB 8'h02
`define MIN_COUNT_DIMM 8'h09

`endif

// [include/alert_pkg.sv]
// Types shared by the alert status and mask logic.
package alert_pkg;

  // Pushed-temperature status layout, msb first.
  typedef struct packed {
    logic [3:0] overtemp;
    logic [3:0] alert;
  } push_status_t;

  // CPU channel status layout, msb first.
  typedef struct packed {
    logic io_rail;
    logic short_byte_count;
    logic [2:0] cpu_ch_limit;
    logic generic_cpu_error_mask_a;
    logic overtemp_timer;
    logic completion_code;
  } cpu_status_t;

  // Register access strobes from the slave serial port.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [rtl/event_flag_bank.sv]
// Sticky event flags with clear-on-read and optional hold while present.
module event_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [WIDTH-1:0] set_i, // event pulses or levels
  input wire logic [WIDTH-1:0] hold_i, // condition still present
  input wire logic clr_i, // status read strobe
  output logic [WIDTH-1:0] flags_o // sticky flags
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // A set in the same cycle as the read clear wins, so no event is lost.
  always_comb begin
    flags_next = set_i | (flags_reg & (~{WIDTH{clr_i}} | hold_i));
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;
endmodule

// [rtl/limit_window_check.sv]
// Registered comparison of a sampled value against a low and high limit.
module limit_window_check #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic valid_i, // new sample strobe
  input wire logic [WIDTH-1:0] value_i, // sampled value
  input wire logic [WIDTH-1:0] low_i, // low limit
  input wire logic [WIDTH-1:0] high_i, // high limit
  output logic outside_o // last sample outside the window
);
  logic outside_reg;
  logic outside_next;

  always_comb begin
    outside_next = outside_reg;
    if (valid_i) begin
      outside_next = (value_i < low_i) || (value_i > high_i);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      outside_reg <= 1'b0;
    end else begin
      outside_reg <= outside_next;
    end
  end

  assign outside_o = outside_reg;
endmodule

// [verification/alert_status_mask_sva.sv]
// Port assertions for the alert status and mask block.
module alert_status_mask_sva (
  input wire logic sys_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic [7:0] reg_addr_i, // address
  input wire logic reg_wr_i, // write
  input wire logic reg_rd_i, // read
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic completion_code_evt_i, // event
  input wire logic overtemp_timer_exceeded_i, // level
  input wire logic [3:0] cpu_limit_evt_i, // limits
  input wire logic cpu_data_err_i, // level
  input wire logic cpu_cpu_error_mask_a_err_i, // level
  input wire logic overtemp_cond_i, // level
  input wire logic block_read_done_i, // pulse
  input wire logic [7:0] block_read_count_i, // count
  input wire logic dimm_read_mode_i, // mode
  input wire logic alert_o, // alert
  input wire logic fan_override_o // fan
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Mask shadows rebuilt from port writes
  // ****
  logic [7:0] err_mask_reg, err_mask_next, cpu_mask_reg, cpu_mask_next;
  logic short_cnt, fan_cause;
  always_comb begin
    err_mask_next = err_mask_reg;
    cpu_mask_next = cpu_mask_reg;
    if (reg_wr_i && reg_addr_i == 8'h82) begin
      err_mask_next = reg_wdata_i & 8'h7F;
    end
    if (reg_wr_i && reg_addr_i == 8'h83) begin
      cpu_mask_next = reg_wdata_i;
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_mask_reg <= 8'h00;
      cpu_mask_reg <= 8'h00;
    end else begin
      err_mask_reg <= err_mask_next;
      cpu_mask_reg <= cpu_mask_next;
    end
  end
  assign short_cnt = block_read_done_i && (block_read_count_i <
    (dimm_read_mode_i ? 8'h09 : 8'h02));
  assign fan_cause = (cpu_data_err_i && !err_mask_reg[1]) ||
    (cpu_cpu_error_mask_a_err_i && !err_mask_reg[2]);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence cc_seen;
    completion_code_evt_i ##1 !cpu_mask_reg[0];
  endsequence
  sequence tmr_seen;
    overtemp_timer_exceeded_i ##1 !cpu_mask_reg[1];
  endsequence
  sequence cnt_seen;
    short_cnt ##1 !cpu_mask_reg[6];
  endsequence
  a_cc_alert: assert property (cc_seen |=> alert_o)
    else $error("no alert after completion code");
  a_timer_alert: assert property (tmr_seen |=> alert_o)
    else $error("no alert after timer limit");
  a_count_alert: assert property (cnt_seen |=> alert_o)
    else $error("no alert after short byte count");
  a_ovt_alert: assert property (overtemp_cond_i && !err_mask_reg[3]
    |=> alert_o) else $error("no alert on overtemperature");
  a_ch0_alert: assert property (cpu_limit_evt_i[0] && !err_mask_reg[0]
    |=> alert_o) else $error("no alert on channel 0 limit");
  a_fan_follow: assert property (
    ##1 fan_override_o == $past(fan_cause))
    else $error("fan override differs from its causes");
  a_push_mask_rsvd: assert property (reg_rd_i && reg_addr_i == 8'h7F
    |=> reg_rdata_o[7:4] == 4'h0) else $error("reserved mask bits set");
  a_cpu_mask_back: assert property (reg_rd_i && !reg_wr_i &&
    reg_addr_i == 8'h83 |=> reg_rdata_o == $past(cpu_mask_reg))
    else $error("mask read back differs");
endmodule

bind alert_status_mask_logic alert_status_mask_sva u_sva (.sys_clk_i,
  .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .completion_code_evt_i, .overtemp_timer_exceeded_i,
  .cpu_limit_evt_i, .cpu_data_err_i, .cpu_cpu_error_mask_a_err_i, .overtemp_cond_i,
  .block_read_done_i, .block_read_count_i, .dimm_read_mode_i, .alert_o,
  .fan_override_o);

// [verification/test_alert_status_mask_logic.sv]
// Self-checking bench for the alert status and mask block.
module test_alert_status_mask_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, alert_o, fan_override_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, block_read_count_i;
  logic [3:0] push_alert_evt_i, push_overtemp_evt_i, cpu_limit_evt_i;
  logic completion_code_evt_i, overtemp_timer_exceeded_i;
  logic generic_cpu_error_mask_a_err_evt_i, cpu_data_err_i, cpu_cpu_error_mask_a_err_i;
  logic overtemp_cond_i, block_read_done_i, dimm_read_mode_i;
  logic vtt_sample_valid_i;
  logic [7:0] vtt_value_i, vtt_high_limit_i, rd_val;
  int errors, tests_run;
  alert_status_mask_logic dut (.sys_clk_i, .sys_rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .push_alert_evt_i,
    .push_overtemp_evt_i, .completion_code_evt_i,
    .overtemp_timer_exceeded_i, .generic_cpu_error_mask_a_err_evt_i, .cpu_limit_evt_i,
    .cpu_data_err_i, .cpu_cpu_error_mask_a_err_i, .overtemp_cond_i, .block_read_done_i,
    .block_read_count_i, .dimm_read_mode_i, .vtt_sample_valid_i,
    .vtt_value_i, .vtt_high_limit_i, .alert_o, .fan_override_o);
  initial begin
    sys_clk_i = 1'h0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ****
  // Port tasks, all entered just after a falling edge
  // ****
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    tests_run++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Each access ends with an idle cycle, so back-to-back calls never lower
  // and raise a strobe in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    cyc(1);
    reg_wr_i = 1'h0;
    cyc(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    cyc(1);
    reg_rd_i = 1'h0;
    chk($sformatf("reg %h", a), ex, reg_rdata_o);
    cyc(1);
  endtask
  // Index 3 to 5 are channels 1 to 3; 7 to 10 are the unlatched alert levels, 8 and 9 also driving the fan.
  task automatic evt(input int i, input logic v);
    case (i)
      0: completion_code_evt_i = v;
      1: overtemp_timer_exceeded_i = v;
      2: generic_cpu_error_mask_a_err_evt_i = v;
      6: block_read_done_i = v;
      7: cpu_limit_evt_i[0] = v;
      8: cpu_data_err_i = v;
      9: cpu_cpu_error_mask_a_err_i = v;
      10: overtemp_cond_i = v;
      default: cpu_limit_evt_i[i-2] = v;
    endcase
  endtask
  task automatic pulse(input int i);
    evt(i, 1'h1);
    cyc(1);
    evt(i, 1'h0);
    cyc(1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [7:0] ad [7] = '{8'h7E, 8'h7F, 8'h81, 8'h82, 8'h83, 8'h84, 8'h90};
    logic [7:0] ex [7] = '{8'h00, 8'h0F, 8'h00, 8'h7F, 8'hFF, 8'hFF, 8'h00};
    chk("outputs", 8'h00, {6'h00, alert_o, fan_override_o});
    for (int i = 0; i < 7; i++) begin
      rchk(ad[i], 8'h00);
      wr(ad[i], 8'hFF);
      rchk(ad[i], ex[i]);
      wr(ad[i], 8'h00);
    end
    $display("t_regs done");
  endtask
  task automatic t_push();
    for (int m = 0; m < 2; m++) begin
      wr(8'h7F, m ? 8'h0F : 8'h00);
      wr(8'h82, m ? 8'h08 : 8'h00);
      push_alert_evt_i = 4'h5;
      push_overtemp_evt_i = 4'hA;
      cyc(1);
      push_alert_evt_i = 4'h0;
      push_overtemp_evt_i = 4'h0;
      cyc(1);
      chk("alert", {7'h00, m == 0}, {7'h00, alert_o});
      rchk(8'h7E, 8'hA5);
      rchk(8'h7E, 8'h00);
    end
    wr(8'h7F, 8'h00);
    wr(8'h82, 8'h00);
    chk("alert", 8'h00, {7'h00, alert_o});
    $display("t_push done");
  endtask
  task automatic t_cpu();
    for (int i = 0; i < 7; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(8'h83, 8'(m << i));
        pulse(i);
        chk("alert", {7'h00, m == 0}, {7'h00, alert_o});
        rchk(8'h81, 8'(1 << i));
        cyc(1);
      end
    end
    wr(8'h83, 8'h00);
    $display("t_cpu done");
  endtask
  task automatic t_count();
    logic [8:0] cs [4] = '{9'h002, 9'h001, 9'h109, 9'h108};
    for (int i = 0; i < 4; i++) begin
      {dimm_read_mode_i, block_read_count_i} = cs[i];
      pulse(6);
      rchk(8'h81, (i % 2) ? 8'h40 : 8'h00);
    end
    {dimm_read_mode_i, block_read_count_i} = 9'h001;
    $display("t_count done");
  endtask
  task automatic t_rail();
    wr(8'h84, 8'h20);
    // Low, back in window, high, back in window: each excursion sets the
    // flag, which stays until a read finds the rail back in window.
    for (int k = 0; k < 4; k++) begin
      vtt_value_i = k[0] ? 8'h50 : (k[1] ? 8'hD0 : 8'h10);
      vtt_sample_valid_i = 1'h1;
      cyc(1);
      vtt_sample_valid_i = 1'h0;
      cyc(2);
      chk("alert", 8'h01, {7'h00, alert_o});
      rchk(8'h81, 8'h80);
      rchk(8'h81, k[0] ? 8'h00 : 8'h80);
      chk("alert", {7'h00, !k[0]}, {7'h00, alert_o});
    end
    wr(8'h84, 8'h00);
    $display("t_rail done");
  endtask
  task automatic t_level();
    for (int k = 0; k < 4; k++) begin
      evt(k + 7, 1'h1);
      cyc(1);
      chk("alert", 8'h01, {7'h00, alert_o});
      chk("fan", {7'h00, k == 1 || k == 2}, {7'h00, fan_override_o});
      wr(8'h82, 8'(1 << k));
      cyc(1);
      chk("masked", 8'h00, 8'({alert_o, fan_override_o}));
      evt(k + 7, 1'h0);
      wr(8'h82, 8'h00);
    end
    $display("t_level done");
  endtask
  task automatic test_done();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, push_alert_evt_i} = '0;
    {push_overtemp_evt_i, cpu_limit_evt_i, completion_code_evt_i} = '0;
    {overtemp_timer_exceeded_i, generic_cpu_error_mask_a_err_evt_i, cpu_data_err_i} = '0;
    {cpu_cpu_error_mask_a_err_i, overtemp_cond_i, block_read_done_i} = '0;
    {dimm_read_mode_i, vtt_sample_valid_i, vtt_value_i} = '0;
    block_read_count_i = 8'h01;
    vtt_high_limit_i = 8'hC0;
    sys_rst_i = 1'h1;
    cyc(10);
    sys_rst_i = 1'h0;
    t_regs();
    t_push();
    t_cpu();
    t_count();
    t_rail();
    t_level();
    test_done();
  end
  // The scenarios need well under a thousand cycles.
  initial begin
    #1000000;
    errors++;
    $display("[ERR] watchdog expected finish seen hang");
    test_done();
  end
endmodule
